// File: inc/tx_pattern_map.svh
// Register map, field positions, reset values and timing counts of the
// transmit pattern generator. Included by the package users; definitions only.
// What this block does
// - Pattern three: 8 bits at 23:16 of two/three register, rw, reset zero.
// - Pattern two: 8 bits at 7:0; bits 31:24 and 15:8 reserved, read-only.
// - Symbol-one burst length code 30:27 maps to 8..256 bits by table.
// - Symbol-zero burst length code 22:19 uses the same sixteen-entry table.
// - Bit 26 picks zero or one bits for the symbol-one burst.
// - Bit 25 set: symbol one is its burst alone, no pattern bits.
// - Bit 24 set: symbol one gets a burst sized by its length code.
// - Bit 18 picks zero or one bits for the symbol-zero burst.
// - Bit 17 set: symbol zero is its burst alone, no pattern bits.
// - Bit 16 set: symbol zero gets a burst sized by its length code.
// - Bits 15:13 give symbol-three valid bits as value plus one.
// - Bits 12:10 give symbol-two valid bits as value plus one.
// - Bits 9:5 give symbol-one valid bits as value plus one, up to 31.
// - Bits 4:0 give symbol-zero valid bits as value plus one, up to 31.
// - Symbols zero and one patterns live in full 32-bit registers, reset zero.
// - Frame configuration selects opening and closing symbol; zero selects none.
`ifndef TX_PATTERN_MAP_SVH
`define TX_PATTERN_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_PAT_ONE 10'h00A
`define IDX_PAT_ZERO 10'h00B
`define IDX_TX_PATTERN_TWO_THREE_DEFINITION 10'h00D
`define IDX_TX_PATTERN_SYMBOL_CONFIGURATION 10'h00E
`define IDX_FRAME_CFG 10'h00F
`define IDX_CTRL 10'h010

// Reset values
`define RST_PAT_WORD 32'h00000000
`define RST_PAT_BYTE 8'h00
`define RST_SYM_CFG 32'h00000000
`define RST_FRAME_SEL 4'h0

// Two/three definition register fields
`define F_PAT_THREE_HI 23
`define F_PAT_THREE_LO 16
`define F_PAT_TWO_HI 7
`define F_PAT_TWO_LO 0

// Symbol configuration fields; reserved bits 31 and 23 masked off
`define SYM_CFG_RW_MASK 32'h7F7FFFFF
`define F_ONE_BLEN_HI 30
`define F_ONE_BLEN_LO 27
`define F_ONE_BPOL 26
`define F_ONE_BALONE 25
`define F_ONE_BON 24
`define F_ZERO_BLEN_HI 22
`define F_ZERO_BLEN_LO 19
`define F_ZERO_BPOL 18
`define F_ZERO_BALONE 17
`define F_ZERO_BON 16
`define F_THREE_LEN_HI 15
`define F_THREE_LEN_LO 13
`define F_TWO_LEN_HI 12
`define F_TWO_LEN_LO 10
`define F_ONE_LEN_HI 9
`define F_ONE_LEN_LO 5
`define F_ZERO_LEN_HI 4
`define F_ZERO_LEN_LO 0
`define LEN5_MAX_CODE 5'h1E

// Frame configuration and control fields
`define F_STOP_SEL_HI 3
`define F_STOP_SEL_LO 2
`define F_START_SEL_HI 1
`define F_START_SEL_LO 0
`define F_CTRL_GO 0
`define F_CTRL_BUSY 1

// Last bit divider count; a bit lasts sixteen core clock cycles
`define BIT_DIV_LAST 4'hF

`endif

// File: inc/tx_pattern_pkg.sv
// Types shared by the transmit pattern generator files.
// Assumes the map header is compiled alongside.
package tx_pattern_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_BURST,
    ST_PATTERN,
    ST_NEXT
  } gen_state_t;

  typedef logic [1:0] symbol_id_t;
  typedef logic [8:0] burst_len_t;

endpackage

// File: logic/burst_length_table.sv
// Burst length lookup: four-bit code to number of burst bits.
// Assumes a registered caller; output is purely combinational.
`timescale 1ns/10ps
`default_nettype none
module burst_length_table
  import tx_pattern_pkg::*;
(
  // Code in
  input wire logic [3:0] code,
  // Length out
  output var burst_len_t bits
);

  always_comb begin
    case (code)
      4'h0: bits = 9'h008;
      4'h1: bits = 9'h00C;
      4'h2: bits = 9'h010;
      4'h3: bits = 9'h018;
      4'h4: bits = 9'h020;
      4'h5: bits = 9'h028;
      4'h6: bits = 9'h030;
      4'h7: bits = 9'h040;
      4'h8: bits = 9'h050;
      4'h9: bits = 9'h060;
      4'hA: bits = 9'h070;
      4'hB: bits = 9'h080;
      4'hC: bits = 9'h0A0;
      4'hD: bits = 9'h0C0;
      4'hE: bits = 9'h0E0;
      default: bits = 9'h100;
    endcase
  end

endmodule
`default_nettype wire

// File: logic/tx_pattern_gen.sv
// Transmit pattern generator: APB register file for the four programmable
// symbols and frame selection, plus a serialiser that sends the opening and
// closing symbols of a frame. Assumes APB3 master, one clock, async reset.
`timescale 1ns/10ps
`default_nettype none
`include "tx_pattern_map.svh"
module tx_pattern_gen
  import tx_pattern_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial bit stream to the modulator
  output logic tx_bit,
  output logic tx_bit_strobe,
  output logic tx_active,
  output logic [1:0] tx_symbol_id,
  output logic tx_frame_done
);

  // Register storage
  logic [31:0] pat_one_bits_reg;
  logic [31:0] pat_zero_bits_reg;
  logic [7:0] pattern_two_bits_reg;
  logic [7:0] pattern_three_bits_reg;
  logic [31:0] sym_cfg_reg;
  logic [3:0] frame_sel_reg;
  // APB answer flops
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // Generator state
  gen_state_t state_reg;
  logic stage_reg;
  logic [8:0] cnt_reg;
  logic [31:0] shift_reg;
  logic [3:0] div_reg;
  symbol_id_t sym_reg;
  logic tx_bit_reg;
  logic tx_strobe_reg;
  logic frame_done_reg;

  // Address decode
  wire [9:0] idx = paddr[11:2];
  wire hit_one = (idx == `IDX_PAT_ONE);
  wire hit_zero = (idx == `IDX_PAT_ZERO);
  wire hit_two_three = (idx == `IDX_TX_PATTERN_TWO_THREE_DEFINITION);
  wire hit_cfg = (idx == `IDX_TX_PATTERN_SYMBOL_CONFIGURATION);
  wire hit_frame = (idx == `IDX_FRAME_CFG);
  wire hit_ctrl = (idx == `IDX_CTRL);
  wire hit_any = hit_one | hit_zero | hit_two_three | hit_cfg | hit_frame | hit_ctrl;
  wire setup_phase = psel & ~penable;
  wire wr_commit = psel & penable & pready_reg & pwrite & hit_any;
  wire busy = (state_reg != ST_IDLE);
  // A start request while a frame runs is dropped, not queued
  wire go = wr_commit & hit_ctrl & pwdata[`F_CTRL_GO] & ~busy;

  // Configuration fields
  wire [3:0] one_blen = sym_cfg_reg[`F_ONE_BLEN_HI:`F_ONE_BLEN_LO];
  wire [3:0] zero_blen = sym_cfg_reg[`F_ZERO_BLEN_HI:`F_ZERO_BLEN_LO];
  wire [4:0] one_len = sym_cfg_reg[`F_ONE_LEN_HI:`F_ONE_LEN_LO];
  wire [4:0] zero_len = sym_cfg_reg[`F_ZERO_LEN_HI:`F_ZERO_LEN_LO];
  wire [2:0] two_len = sym_cfg_reg[`F_TWO_LEN_HI:`F_TWO_LEN_LO];
  wire [2:0] three_len = sym_cfg_reg[`F_THREE_LEN_HI:`F_THREE_LEN_LO];
  wire [1:0] start_sel = frame_sel_reg[`F_START_SEL_HI:`F_START_SEL_LO];
  wire [1:0] stop_sel = frame_sel_reg[`F_STOP_SEL_HI:`F_STOP_SEL_LO];

  wire [4:0] one_len_c = (one_len > `LEN5_MAX_CODE) ? `LEN5_MAX_CODE : one_len;
  wire [4:0] zero_len_c = (zero_len > `LEN5_MAX_CODE) ? `LEN5_MAX_CODE : zero_len;
  wire [8:0] one_bits_n = {4'h0, one_len_c} + 9'h001;
  wire [8:0] zero_bits_n = {4'h0, zero_len_c} + 9'h001;
  wire [8:0] two_bits_n = {6'h00, two_len} + 9'h001;
  wire [8:0] three_bits_n = {6'h00, three_len} + 9'h001;

  wire [1:0] sel_code = stage_reg ? stop_sel : start_sel;
  wire sel_none = (sel_code == 2'b00);
  // Opening codes name symbols 0..2, closing codes name symbols 1..3
  wire [1:0] sel_sym = stage_reg ? sel_code : (sel_code - 2'b01);

  // Per-symbol view of the chosen symbol
  wire is_zero = (sel_sym == 2'd0);
  wire is_one = (sel_sym == 2'd1);
  // Symbols two and three have no burst, so their burst switches are don't-care
  // burst enables
  wire sel_bon = (is_zero & sym_cfg_reg[`F_ZERO_BON]) | (is_one & sym_cfg_reg[`F_ONE_BON]);
  wire sel_alone = is_zero ? sym_cfg_reg[`F_ZERO_BALONE] : sym_cfg_reg[`F_ONE_BALONE];
  wire sel_pol = is_zero ? sym_cfg_reg[`F_ZERO_BPOL] : sym_cfg_reg[`F_ONE_BPOL];
  wire [3:0] sel_blen = is_zero ? zero_blen : one_blen;
  burst_len_t sel_burst_bits;

  burst_length_table u_table (
    .code(sel_blen),
    .bits(sel_burst_bits)
  );

  wire [31:0] sel_pattern =
    (sel_sym == 2'd0) ? pat_zero_bits_reg :
    (sel_sym == 2'd1) ? pat_one_bits_reg :
    (sel_sym == 2'd2) ? {24'h000000, pattern_two_bits_reg} :
                        {24'h000000, pattern_three_bits_reg};
  wire [8:0] sel_pat_bits =
    (sel_sym == 2'd0) ? zero_bits_n :
    (sel_sym == 2'd1) ? one_bits_n :
    (sel_sym == 2'd2) ? two_bits_n : three_bits_n;

  // Bit-rate enable; held in phase with the start of each frame
  wire tick = (div_reg == `BIT_DIV_LAST);
  wire last_cnt = (cnt_reg == 9'h001);

  // Read data mux; reserved bits read as zero
  wire [31:0] rd_two_three = {8'h00, pattern_three_bits_reg, 8'h00, pattern_two_bits_reg};
  wire [31:0] rd_ctrl = {30'h00000000, busy, 1'b0};
  wire [31:0] rd_data =
    hit_one ? pat_one_bits_reg :
    hit_zero ? pat_zero_bits_reg :
    hit_two_three ? rd_two_three :
    hit_cfg ? sym_cfg_reg :
    hit_frame ? {28'h0000000, frame_sel_reg} :
    hit_ctrl ? rd_ctrl : 32'h00000000;

  // APB answer: captured in setup, given in the first access cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~hit_any;
      if (setup_phase & ~pwrite) begin
        prdata_reg <= rd_data;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pat_one_bits_reg <= `RST_PAT_WORD;
      pat_zero_bits_reg <= `RST_PAT_WORD;
      pattern_two_bits_reg <= `RST_PAT_BYTE;
      pattern_three_bits_reg <= `RST_PAT_BYTE;
    end else if (wr_commit) begin
      if (hit_one) begin
        pat_one_bits_reg <= pwdata;
      end
      if (hit_zero) begin
        pat_zero_bits_reg <= pwdata;
      end
      if (hit_two_three) begin
        pattern_two_bits_reg <= pwdata[`F_PAT_TWO_HI:`F_PAT_TWO_LO];
        pattern_three_bits_reg <= pwdata[`F_PAT_THREE_HI:`F_PAT_THREE_LO];
      end
    end
  end

  // Polarity and burst-only are read live during a frame; avoid writes while busy
  // Configuration registers; writes take effect at once, even while a frame runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sym_cfg_reg <= `RST_SYM_CFG;
      frame_sel_reg <= `RST_FRAME_SEL;
    end else if (wr_commit) begin
      if (hit_cfg) begin
        sym_cfg_reg <= pwdata & `SYM_CFG_RW_MASK;
      end
      if (hit_frame) begin
        frame_sel_reg <= pwdata[3:0];
      end
    end
  end

  // Bit divider
  // Held at zero while idle so every frame opens on a full bit period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 4'h0;
    end else if (!busy || tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // Serialiser state machine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      stage_reg <= 1'b0;
      cnt_reg <= 9'h000;
      shift_reg <= 32'h00000000;
      sym_reg <= 2'd0;
      tx_bit_reg <= 1'b0;
      tx_strobe_reg <= 1'b0;
      frame_done_reg <= 1'b0;
    end else begin
      tx_strobe_reg <= 1'b0;
      frame_done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            stage_reg <= 1'b0;
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          sym_reg <= sel_sym;
          shift_reg <= sel_pattern;
          if (sel_none) begin
            // An empty stage still passes through NEXT to keep the stage order
            state_reg <= ST_NEXT;
          end else if (sel_bon) begin
            cnt_reg <= sel_burst_bits;
            state_reg <= ST_BURST;
          end else begin
            cnt_reg <= sel_pat_bits;
            state_reg <= ST_PATTERN;
          end
        end
        ST_BURST: begin
          if (tick) begin
            tx_bit_reg <= sel_pol;
            tx_strobe_reg <= 1'b1;
            cnt_reg <= cnt_reg - 9'h001;
            if (last_cnt) begin
              if (sel_alone) begin
                state_reg <= ST_NEXT;
              end else begin
                cnt_reg <= sel_pat_bits;
                state_reg <= ST_PATTERN;
              end
            end
          end
        end
        ST_PATTERN: begin
          if (tick) begin
            tx_bit_reg <= shift_reg[0];
            tx_strobe_reg <= 1'b1;
            shift_reg <= {1'b0, shift_reg[31:1]};
            cnt_reg <= cnt_reg - 9'h001;
            if (last_cnt) begin
              state_reg <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          if (!stage_reg) begin
            stage_reg <= 1'b1;
            state_reg <= ST_LOAD;
          end else begin
            frame_done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_bit = tx_bit_reg;
  assign tx_bit_strobe = tx_strobe_reg;
  assign tx_symbol_id = sym_reg;
  assign tx_frame_done = frame_done_reg;

  // Active flag as its own flop so the output is registered
  logic active_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= go | (busy & ~(state_reg == ST_NEXT & stage_reg));
    end
  end
  assign tx_active = active_reg;

endmodule
`default_nettype wire

// File: testbench/tx_pattern_gen_assertions.sv
// Port-level checks of the pattern generator.
// Bound to the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tx_pattern_gen_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Stream
  input wire logic tx_bit,
  input wire logic tx_bit_strobe,
  input wire logic tx_active,
  input wire logic [1:0] tx_symbol_id,
  input wire logic tx_frame_done
);
  wire logic [9:0] idx = paddr[11:2];
  wire logic hit = idx inside {10'h00A, 10'h00B, 10'h00D, 10'h00E, 10'h00F, 10'h010};
  wire logic go = psel && penable && pready && pwrite && idx == 10'h010 && pwdata[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  // Bit period is sixteen cycles, so fifteen quiet cycles follow a strobe
  sequence s_quiet;
    (!tx_bit_strobe)[*8] ##1 (!tx_bit_strobe)[*7];
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_on_unmapped: assert property (pready |-> pslverr == !hit)
    else $error("pslverr does not match the map");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_strobe_in_frame: assert property (tx_bit_strobe |-> tx_active)
    else $error("strobe outside a frame");
  a_strobe_bit_gap: assert property (tx_bit_strobe |=> s_quiet)
    else $error("strobes closer than a bit period");
  a_done_then_idle: assert property (tx_frame_done |=> !tx_frame_done && !tx_active)
    else $error("frame done not followed by idle");
  // A frame with both stages empty stays active for four cycles only
  a_go_starts_frame: assert property (go && !tx_active |=> (tx_active && !tx_bit_strobe)[*4])
    else $error("go did not start a frame");
endmodule
`default_nettype wire

// File: testbench/card_model.sv
// Card side: captures each transmitted bit with its symbol number.
// Assumes the strobe marks the cycle in which the bit is valid.
`timescale 1ns/10ps
`default_nettype none
module card_model (
  // Clock
  input wire logic core_clk,
  // Bit stream in
  input wire logic tx_bit,
  input wire logic tx_bit_strobe,
  input wire logic [1:0] tx_symbol_id,
  // Received bit out
  output logic rx_bit,
  output logic rx_valid,
  output logic [1:0] rx_sym
);
  always @(posedge core_clk) begin
    rx_valid <= tx_bit_strobe;
    if (tx_bit_strobe) begin
      rx_bit <= tx_bit;
      rx_sym <= tx_symbol_id;
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_tx_pattern_gen.sv
// Self-checking bench of the pattern generator.
// APB driven by tasks; expected bits queued and matched at the card.
`timescale 1ns/10ps
`default_nettype none
module test_tx_pattern_gen;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, p0 = 0, p1 = 0, p23 = 0, cfg = 0;
  wire logic [31:0] prdata;
  wire logic [1:0] tx_symbol_id, rx_sym;
  wire logic pready, pslverr, tx_bit, tx_bit_strobe, tx_active, tx_frame_done, rx_bit, rx_valid;
  logic [32:0] rq[$];
  logic [2:0] bq[$];
  int miscompares = 0, num_checks = 0, cycles = 0;
  int bt[16] = '{8, 12, 16, 24, 32, 40, 48, 64, 80, 96, 112, 128, 160, 192, 224, 256};
  logic [11:0] ad[4] = '{12'h028, 12'h02C, 12'h034, 12'h038};

  tx_pattern_gen i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .tx_active(tx_active), .tx_symbol_id(tx_symbol_id), .tx_frame_done(tx_frame_done));
  card_model i_card (.core_clk(core_clk), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .tx_symbol_id(tx_symbol_id), .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_sym(rx_sym));

  initial forever #5 core_clk = ~core_clk;

  task conclude;
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task check(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      conclude();
    end
  end

  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1)
      check({pslverr, pwrite ? 32'h0 : prdata}, rq.pop_front());

  always @(posedge core_clk)
    if (rx_valid === 1'b1)
      check({rx_sym, rx_bit}, bq.size() ? bq.pop_front() : 3'bxxx);

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    rq.push_back(e);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 0);
    case (a)
      12'h028: p1 = d;
      12'h02C: p0 = d;
      12'h034: p23 = d & 32'h00FF00FF;
      12'h038: cfg = d & 32'h7F7FFFFF;
      default: ;
    endcase
  endtask

  // Burst first, then valid pattern bits from bit 0 upward
  task note(input int id);
    int n, i;
    logic on;
    logic [31:0] pat;
    on = id < 2 && cfg[16 + 8 * id];
    pat = id == 0 ? p0 : id == 1 ? p1 : id == 2 ? p23[7:0] : p23[23:16];
    n = id == 0 ? cfg[4:0] : id == 1 ? cfg[9:5] : id == 2 ? cfg[12:10] : cfg[15:13];
    if (n == 31) n = 30;
    if (on) for (i = 0; i < bt[id ? cfg[30:27] : cfg[22:19]]; i++)
      bq.push_back({id[1:0], cfg[18 + 8 * id]});
    if (!(on && cfg[17 + 8 * id])) for (i = 0; i <= n; i++)
      bq.push_back({id[1:0], pat[i]});
  endtask

  task frame(input logic [3:0] fc);
    wr(12'h03C, {28'h0, fc});
    if (fc[1:0] != 0) note(fc[1:0] - 1);
    if (fc[3:2] != 0) note(fc[3:2]);
    wr(12'h040, 32'h1);
    // Frame running: busy reads back set and, when fc is not zero, a second start is dropped
    apb(0, 12'h040, 0, {1'b0, 32'h2});
    check(tx_active, 1);
    if (fc != 0) wr(12'h040, 32'h1);
    while (tx_frame_done !== 1'b1) begin
      @(posedge core_clk);
    end
    @(posedge core_clk);
    check(bq.size(), 0);
    check(tx_active, 0);
  endtask

  initial begin
    void'($urandom(32'h6aa4));
    repeat (6) @(posedge core_clk);
    rst <= 0;
    foreach (ad[k]) apb(0, ad[k], 0, 0);
    apb(0, 12'h030, 0, {1'b1, 32'h0});
    apb(1, 12'h030, 32'hFFFFFFFF, {1'b1, 32'h0});
    wr(12'h034, 32'hFFFFFFFF);
    wr(12'h038, 32'hFFFFFFFF);
    wr(12'h028, $urandom);
    wr(12'h02C, $urandom);
    apb(0, 12'h028, 0, {1'b0, p1});
    apb(0, 12'h02C, 0, {1'b0, p0});
    apb(0, 12'h034, 0, {1'b0, p23});
    apb(0, 12'h038, 0, {1'b0, cfg});
    wr(12'h038, 32'h000003FF);
    frame(4'b0101);
    wr(12'h038, 32'h0000FC00);
    wr(12'h034, $urandom);
    frame(4'b1111);
    frame(4'b0100);
    wr(12'h038, 32'h01050085);
    frame(4'b0101);
    for (int c = 0; c < 16; c++) begin
      wr(12'h038, {1'b0, c[3:0], c[0], 2'b11, 1'b0, c[3:0], ~c[0], 2'b11, 16'h0});
      frame(4'b0101);
    end
    repeat (2) begin
      wr(12'h038, $urandom);
      wr(12'h028, $urandom);
      wr(12'h02C, $urandom);
      wr(12'h034, $urandom);
      frame(4'($urandom));
    end
    conclude();
  end
endmodule

bind tx_pattern_gen tx_pattern_gen_assertions i_chk (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit(tx_bit),
  .tx_bit_strobe(tx_bit_strobe), .tx_active(tx_active), .tx_symbol_id(tx_symbol_id),
  .tx_frame_done(tx_frame_done));
`default_nettype wire
